/* File: design/sfrh_buf.sv */
// sfrh_buf: small fifo with valid/ready on both sides and a flush
// assumes one clock domain; flush empties it in one cycle
`timescale 1ns/10ps
module sfrh_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(D);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_reg != FULL);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];

  always_comb begin
    push     = in_valid_i && in_ready_o && ce_i;
    pop      = out_valid_o && out_ready_i && ce_i;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    if (flush_i && ce_i) begin
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push && !flush_i) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
endmodule

/* File: design/sfrh_pkg.sv */
// sfrh_pkg: constants and types for the serial flash read path
// assumes nothing; imported by sfrh_read_top and the testbench, not by sfrh_buf or sfrh_sync
package sfrh_pkg;
  localparam logic [7:0] OP_NORMAL      = 8'h03;
  localparam logic [7:0] OP_NORMAL_WIDE = 8'h13;
  localparam logic [7:0] OP_FAST        = 8'h0B;
  localparam logic [7:0] OP_FAST_WIDE   = 8'h0C;
  localparam logic [7:0] OP_QUAD_IO     = 8'hEB;
  localparam logic [7:0] OP_UNIQUE_ID   = 8'h4B;
  localparam logic [7:0] OP_INFO_ROW    = 8'h68;
  localparam logic [5:0] CMD_BITS       = 6'h08;
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
  localparam int         MEM_AW         = 25;
  localparam logic [5:0] STEP_SINGLE    = 6'h01;
  localparam logic [5:0] STEP_QUAD      = 6'h04;
  localparam logic [3:0] BITS_SINGLE_REST = 4'h7;
  localparam logic [3:0] BITS_QUAD_REST = 4'h4;
  localparam logic [4:0] FAST_DUMMY_RESET = 5'h08;
  localparam logic [4:0] QUAD_DUMMY_RESET = 5'h06;
  localparam logic [3:0] OE_SINGLE      = 4'h2;
  localparam logic [3:0] OE_QUAD        = 4'hF;
  localparam int         PIN_SYNC_W     = 7;
  localparam int         BUF_DEPTH      = 2;
  localparam int         BYTE_W         = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfrh_state_t;
endpackage

/* File: design/sfrh_read_top.sv */
// sfrh_read_top: serial flash read path, device end, pins sampled on sys_clk_i
// assumes memory array outside, answering fetches within two sys_clk_i cycles
// Operation
// - normal read 03h narrow/wide, 13h wide
// - opcode and address enter on lane 0
// - decode address bits 23..0 or 24..0
// - input ignored after address in read
// - normal read data follows address, no dummy
// - address increments per byte, wraps to zero
// - read runs until chip select rises
// - reads ignored while write in progress
// - fast read 0Bh narrow/wide, 0Ch wide
// - fast read waits configured dummy clocks
// - sample on rising, shift out falling
// - single-lane output one bit per clock
// - four-lane mode: nibble per clock
// - four-lane fast read configured dummy clocks
// - EBh, 4Bh, 68h use four-lane framing
// - hold acts only while selected, mid-sequence
// - held: outputs released, clock edges ignored
// - hold disabled by dtr, quad enable, reset
`timescale 1ns/10ps
module sfrh_read_top (
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                ce_i,
  input  wire logic                sck_i,
  input  wire logic                cs_n_i,
  input  wire logic                hold_n_i,
  input  wire logic [3:0]          data_lane_i,
  output logic      [3:0]          data_lane_o,
  output logic      [3:0]          data_lane_oe_o,
  input  wire logic                extended_address_flag_i,
  input  wire logic                write_in_progress_flag_i,
  input  wire logic                quad_enable_bit_i,
  input  wire logic                four_lane_instruction_mode_i,
  input  wire logic                dtr_mode_i,
  input  wire logic                hold_pin_is_reset_i,
  input  wire logic [4:0]          fast_dummy_i,
  input  wire logic [4:0]          quad_dummy_i,
  output logic                     fetch_valid_o,
  output logic [sfrh_pkg::MEM_AW-1:0] fetch_addr_o,
  input  wire logic                fetch_ready_i,
  input  wire logic                rdata_valid_i,
  input  wire logic [7:0]          rdata_i,
  output logic                     rdata_ready_o,
  output logic                     busy_o
);
  import sfrh_pkg::*;

  logic [PIN_SYNC_W-1:0] pins_s;
  logic              sck_s;
  logic              cs_s;
  logic              hold_s;
  logic [3:0]        lane_s;
  sfrh_state_t       state_reg;
  sfrh_state_t       state_next;
  logic [5:0]        cnt_reg;
  logic [5:0]        cnt_next;
  logic [5:0]        cnt_plus;
  logic [5:0]        step;
  logic [31:0]       sh_reg;
  logic [31:0]       sh_next;
  logic [MEM_AW-1:0] addr_reg;
  logic [MEM_AW-1:0] addr_next;
  logic              wide_reg;
  logic              wide_next;
  logic              fast_reg;
  logic              fast_next;
  logic              quad_reg;
  logic              quad_next;
  logic              sck_d_reg;
  logic              pend_reg;
  logic              pend_next;
  logic              on_reg;
  logic              on_next;
  logic [7:0]        osh_reg;
  logic [7:0]        osh_next;
  logic [3:0]        ocnt_reg;
  logic [3:0]        ocnt_next;
  logic [3:0]        lane_reg;
  logic [3:0]        lane_next;
  logic [3:0]        oe_reg;
  logic [3:0]        oe_next;
  logic [4:0]        dummy_n;
  logic [7:0]        byte_v;
  logic              rise;
  logic              fall;
  logic              hold_en;
  logic              held;
  logic              active;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic              buf_out_ready;
  logic [7:0]        buf_out_data;

  sfrh_sync #(.W(PIN_SYNC_W), .RST_V(7'h06)) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .async_i   ({data_lane_i, hold_n_i, cs_n_i, sck_i}),
    .sync_o    (pins_s)
  );

  assign sck_s  = pins_s[0];
  assign cs_s   = pins_s[1];
  assign hold_s = pins_s[2];
  assign lane_s = pins_s[6:3];

  assign active        = (state_reg == ST_DUMMY) || (state_reg == ST_DATA);
  assign rdata_ready_o = buf_in_ready || !active;

  sfrh_buf #(.W(BYTE_W), .D(BUF_DEPTH)) u_buf (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .flush_i     (cs_s),
    .in_valid_i  (rdata_valid_i && active),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (rdata_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );

  assign rise    = sck_s && !sck_d_reg;
  assign fall    = !sck_s && sck_d_reg;
  assign hold_en = !quad_enable_bit_i && !dtr_mode_i && !hold_pin_is_reset_i;
  assign held    = hold_en && !hold_s && !cs_s && (state_reg != ST_IDLE);
  assign step    = quad_reg ? STEP_QUAD : STEP_SINGLE;
  assign cnt_plus = cnt_reg + step;
  assign dummy_n = quad_reg ? quad_dummy_i : fast_dummy_i;
  assign buf_out_ready = fall && !held && !cs_s && (state_reg == ST_DATA) && (ocnt_reg == 4'h0);
  assign byte_v  = (ocnt_reg == 4'h0) ? buf_out_data : osh_reg;
  assign fetch_valid_o = active && !cs_s && !pend_reg && buf_in_ready;
  assign fetch_addr_o  = addr_reg;
  assign data_lane_o    = lane_reg;
  assign data_lane_oe_o = oe_reg;
  assign busy_o         = (state_reg != ST_IDLE);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    wide_next  = wide_reg;
    fast_next  = fast_reg;
    quad_next  = quad_reg;
    pend_next  = pend_reg;
    on_next    = on_reg;
    osh_next   = osh_reg;
    ocnt_next  = ocnt_reg;
    lane_next  = lane_reg;
    if (cs_s) begin
      state_next = ST_IDLE;
      cnt_next   = '0;
      on_next    = 1'b0;
      ocnt_next  = '0;
    end else if (state_reg == ST_IDLE) begin
      state_next = ST_CMD;
      cnt_next   = '0;
      quad_next  = four_lane_instruction_mode_i;
    end else if (rise && !held) begin
      sh_next  = quad_reg ? {sh_reg[27:0], lane_s} : {sh_reg[30:0], lane_s[0]};
      cnt_next = cnt_plus;
      case (state_reg)
        ST_CMD: begin
          if (cnt_plus == CMD_BITS) begin
            cnt_next   = '0;
            state_next = ST_ADDR;
            fast_next  = 1'b1;
            if (write_in_progress_flag_i) begin
              state_next = ST_IGNORE;
            end else if (quad_reg) begin
              case (sh_next[7:0])
                OP_FAST, OP_QUAD_IO: wide_next = extended_address_flag_i;
                OP_FAST_WIDE: wide_next = 1'b1;
                OP_UNIQUE_ID, OP_INFO_ROW: wide_next = 1'b0;
                default: state_next = ST_IGNORE;
              endcase
            end else begin
              case (sh_next[7:0])
                OP_NORMAL: begin
                  wide_next = extended_address_flag_i;
                  fast_next = 1'b0;
                end
                OP_NORMAL_WIDE: begin
                  wide_next = 1'b1;
                  fast_next = 1'b0;
                end
                OP_FAST: wide_next = extended_address_flag_i;
                OP_FAST_WIDE: wide_next = 1'b1;
                default: state_next = ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (cnt_plus == (wide_reg ? ADDR_BITS_WIDE : ADDR_BITS_NARROW)) begin
            cnt_next  = '0;
            addr_next = wide_reg ? sh_next[MEM_AW-1:0] : {1'b0, sh_next[23:0]};
            if (!fast_reg || dummy_n == 5'h00) begin
              state_next = ST_DATA;
            end else begin
              state_next = ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_next >= {1'b0, dummy_n}) begin
            cnt_next   = '0;
            state_next = ST_DATA;
          end
        end
        default: begin
          sh_next  = sh_reg;
          cnt_next = cnt_reg;
        end
      endcase
    end else if (fall && !held && state_reg == ST_DATA) begin
      on_next = 1'b1;
      if (quad_reg) begin
        lane_next = byte_v[7:4];
        osh_next  = {byte_v[3:0], 4'h0};
        ocnt_next = (ocnt_reg == 4'h0) ? BITS_QUAD_REST : ocnt_reg - BITS_QUAD_REST;
      end else begin
        lane_next = {2'b00, byte_v[7], 1'b0};
        osh_next  = {byte_v[6:0], 1'b0};
        ocnt_next = (ocnt_reg == 4'h0) ? BITS_SINGLE_REST : ocnt_reg - 4'h1;
      end
    end
    if (fetch_valid_o && fetch_ready_i) begin
      addr_next = addr_reg + 1'b1;
      pend_next = 1'b1;
    end else if (rdata_valid_i && rdata_ready_o) begin
      pend_next = 1'b0;
    end
    if (state_next == ST_DATA && on_next && !held) begin
      oe_next = quad_reg ? OE_QUAD : OE_SINGLE;
    end else begin
      oe_next = 4'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      sh_reg    <= '0;
      addr_reg  <= '0;
      wide_reg  <= 1'b0;
      fast_reg  <= 1'b0;
      quad_reg  <= 1'b0;
      sck_d_reg <= 1'b0;
      pend_reg  <= 1'b0;
      on_reg    <= 1'b0;
      osh_reg   <= '0;
      ocnt_reg  <= '0;
      lane_reg  <= '0;
      oe_reg    <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      wide_reg  <= wide_next;
      fast_reg  <= fast_next;
      quad_reg  <= quad_next;
      sck_d_reg <= sck_s;
      pend_reg  <= pend_next;
      on_reg    <= on_next;
      osh_reg   <= osh_next;
      ocnt_reg  <= ocnt_next;
      lane_reg  <= lane_next;
      oe_reg    <= oe_next;
    end
  end

  chk_cs_release: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && cs_s |=> oe_reg == 4'h0 && state_reg == ST_IDLE) else $error("select high did not idle");
  chk_wip_ignore: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && !cs_s && rise && !held && state_reg == ST_CMD && cnt_plus == CMD_BITS && write_in_progress_flag_i
    |=> state_reg == ST_IGNORE) else $error("read accepted while busy");
  chk_hold_freeze: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && held |=> $stable(cnt_reg) && $stable(ocnt_reg) && $stable(lane_reg)) else $error("sequence moved in hold");
  chk_hold_hiz: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && held |=> oe_reg == 4'h0) else $error("lanes driven in hold");
  chk_addr_narrow: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && state_reg == ST_ADDR && state_next != ST_ADDR && !cs_s && !wide_reg |=> addr_reg[24] == 1'b0)
    else $error("narrow address kept bit 24");
  chk_addr_step: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && fetch_valid_o && fetch_ready_i |=> addr_reg == $past(addr_reg) + 1'b1) else $error("address not advanced");
  chk_normal_data: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && !cs_s && state_reg == ST_ADDR && state_next != ST_ADDR && !fast_reg |=> state_reg == ST_DATA)
    else $error("normal read not straight to data");
  chk_fast_dummy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && !cs_s && state_reg == ST_ADDR && state_next != ST_ADDR && fast_reg && dummy_n != 5'h00
    |=> state_reg == ST_DUMMY) else $error("fast read skipped dummy");
  chk_single_lane: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !quad_reg |-> oe_reg == 4'h0 || oe_reg == OE_SINGLE) else $error("single mode drove wrong lane");
  chk_data_stays: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && state_reg == ST_DATA |=> state_reg == ST_DATA || state_reg == ST_IDLE) else $error("data phase left early");
endmodule

/* File: design/sfrh_sync.sv */
// sfrh_sync: two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to sys_clk_i
`timescale 1ns/10ps
module sfrh_sync #(
  parameter int            W     = 1,
  parameter logic [W-1:0]  RST_V = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = ce_i ? async_i : meta_reg;
    sync_next = ce_i ? meta_reg : sync_reg;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_V;
      sync_reg <= RST_V;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule

/* File: verif/sfrh_host_model.sv */
// sfrh_host_model: host end of the serial link, clocks read frames
// assumes the bench resolves lane levels and returns them on lane_w_i
`timescale 1ns/10ps
module sfrh_host_model (
  input  wire logic [3:0] lane_w_i,
  input  wire logic [3:0] dut_oe_i,
  output logic            sck_o,
  output logic            cs_n_o,
  output logic            hold_n_o,
  output logic [3:0]      lane_o,
  output logic [3:0]      lane_oe_o
);
  logic [7:0] got[$];
  logic [3:0] hold_oe;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    hold_n_o = 1'b1;
    lane_o = 4'h0;
    lane_oe_o = 4'h0;
  end

  // one serial clock: drive while low, sample late in the high phase
  task automatic pulse(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] smp);
    lane_o = v;
    lane_oe_o = oe;
    #400 sck_o = 1'b1;
    #300 smp = lane_w_i;
    #100 sck_o = 1'b0;
  endtask

  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int nab, dum, input bit q,
                       input int nb, hp, input bit heff, input logic [31:0] junk);
    logic [39:0] sr;
    logic [3:0]  smp;
    logic [7:0]  rb;
    int          hdr;
    int          n;
    int          bpc;
    sr = (nab == 3) ? {op, ad[23:0], 8'h00} : {op, ad};
    bpc = q ? 4 : 1;
    hdr = (8 + nab * 8) / bpc;
    n = 0;
    got.delete();
    hold_oe = 4'hX;
    cs_n_o = 1'b0;
    for (int k = 0; k < hdr + dum + nb * 8 / bpc; k++) begin
      junk = {junk[30:0], junk[31]};
      if (k == hp) begin
        #100 hold_n_o = 1'b0;
        #600 hold_oe = dut_oe_i;
        for (int t = 0; t < 3 && heff; t++) begin
          lane_o = junk[3:0];
          #400 sck_o = 1'b1;
          #400 sck_o = 1'b0;
        end
        #100 hold_n_o = 1'b1;
      end
      if (k < hdr) begin
        pulse(q ? sr[39:36] : {3'h0, sr[39]}, q ? 4'hF : 4'h1, smp);
        sr = sr << bpc;
      end else begin
        pulse(junk[3:0], q ? 4'h0 : 4'h1, smp);
        if (k >= hdr + dum) begin
          rb = q ? {rb[3:0], smp} : {rb[6:0], smp[1]};
          n = n + bpc;
          if (n % 8 == 0) got.push_back(rb);
        end
      end
    end
    cs_n_o = 1'b1;
    lane_oe_o = 4'h0;
    #800;
  endtask
endmodule

/* File: verif/testbench.sv */
// testbench: read frames through the flash read path against a byte model
// assumes the host model clocks the link and memory answers the next cycle
`timescale 1ns/10ps
module testbench;
  import sfrh_pkg::*;
  logic              sys_clk_i, nrst_i, sck_i, cs_n_i, hold_n_i, fetch_valid_o, rdata_valid_i;
  logic              rdata_ready_o, busy_o, extended_address_flag_i, write_in_progress_flag_i;
  logic              quad_enable_bit_i, four_lane_instruction_mode_i, dtr_mode_i, hold_pin_is_reset_i;
  logic [3:0]        data_lane_i, data_lane_o, data_lane_oe_o, h_o, h_oe, last, seen_oe;
  logic [4:0]        fast_dummy_i, quad_dummy_i;
  logic [7:0]        rdata_i;
  logic [MEM_AW-1:0] fetch_addr_o;
  logic [4:0]        dl[4];
  logic [7:0]        qop[5];
  int                err_total, checked, seed;

  sfrh_read_top DUT (
    .sys_clk_i,
    .nrst_i,
    .ce_i                        (1'b1),
    .sck_i,
    .cs_n_i,
    .hold_n_i,
    .data_lane_i,
    .data_lane_o,
    .data_lane_oe_o,
    .extended_address_flag_i,
    .write_in_progress_flag_i,
    .quad_enable_bit_i,
    .four_lane_instruction_mode_i,
    .dtr_mode_i,
    .hold_pin_is_reset_i,
    .fast_dummy_i,
    .quad_dummy_i,
    .fetch_valid_o,
    .fetch_addr_o,
    .fetch_ready_i               (1'b1),
    .rdata_valid_i,
    .rdata_i,
    .rdata_ready_o,
    .busy_o
  );

  sfrh_host_model host (
    .lane_w_i  (data_lane_i),
    .dut_oe_i  (data_lane_oe_o),
    .sck_o     (sck_i),
    .cs_n_o    (cs_n_i),
    .hold_n_o  (hold_n_i),
    .lane_o    (h_o),
    .lane_oe_o (h_oe)
  );

  // undriven lanes flip every cycle so a stale level never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      data_lane_i[i] = data_lane_oe_o[i] ? data_lane_o[i] : h_oe[i] ? h_o[i] : ~last[i];
    end
  end

  function automatic logic [7:0] mem(input logic [MEM_AW-1:0] a);
    return a[7:0] + a[15:8] + a[24:17];
  endfunction

  // memory array: one fetch answered next cycle, held until taken
  always @(posedge sys_clk_i) begin
    if (rdata_valid_i && rdata_ready_o) begin
      rdata_valid_i <= 1'b0;
      rdata_i <= ~rdata_i;
    end
    if (fetch_valid_o) begin
      rdata_valid_i <= 1'b1;
      rdata_i <= mem(fetch_addr_o);
    end
    last <= data_lane_i;
    if (!cs_n_i) seen_oe <= seen_oe | data_lane_oe_o;
  end

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_lane(input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // f = {ext, wip, qe, dtr, reset_sel}
  task automatic run(input logic [7:0] op, input logic [31:0] ad, input bit q, ok, input int nb, hp,
                     input logic [4:0] f);
    int                nab;
    int                dum;
    logic [MEM_AW-1:0] st;
    @(negedge sys_clk_i);
    {extended_address_flag_i, write_in_progress_flag_i, quad_enable_bit_i, dtr_mode_i, hold_pin_is_reset_i} = f;
    four_lane_instruction_mode_i = q;
    seen_oe = 4'h0;
    nab = (q && (op == OP_UNIQUE_ID || op == OP_INFO_ROW)) ? 3 :
          (op == OP_NORMAL_WIDE || op == OP_FAST_WIDE || f[4]) ? 4 : 3;
    dum = (op == OP_NORMAL || op == OP_NORMAL_WIDE) ? 0 : q ? int'(quad_dummy_i) : int'(fast_dummy_i);
    st = (nab == 3) ? {1'b0, ad[23:0]} : ad[24:0];
    host.frame(op, ad, nab, dum, q, nb, hp, f[2:0] == 3'h0, $random(seed));
    if (ok) begin
      for (int i = 0; i < nb; i++) cmp_byte(mem(25'(st + i)), host.got[i]);
      cmp_lane(q ? OE_QUAD : OE_SINGLE, seen_oe);
    end else begin
      cmp_lane(4'h0, seen_oe);
    end
    if (hp >= 0) cmp_lane((f[2:0] == 3'h0) ? 4'h0 : q ? OE_QUAD : OE_SINGLE, host.hold_oe);
    repeat (6) @(negedge sys_clk_i);
    cmp_lane(4'h0, data_lane_oe_o);
    cmp_byte(8'h00, {7'h0, busy_o});
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #6000000;
    err_total++;
    final_report;
  end

  initial begin
    nrst_i = 1'b0;
    {extended_address_flag_i, write_in_progress_flag_i, quad_enable_bit_i, dtr_mode_i, hold_pin_is_reset_i} = 5'h00;
    four_lane_instruction_mode_i = 1'b0;
    fast_dummy_i = FAST_DUMMY_RESET;
    quad_dummy_i = QUAD_DUMMY_RESET;
    rdata_valid_i = 1'b0;
    rdata_i = 8'h00;
    seen_oe = 4'h0;
    last = 4'h0;
    seed = 32'hA9B5CE60;
    err_total = 0;
    checked = 0;
    dl = '{5'h08, 5'h00, 5'h01, 5'h1F};
    qop = '{OP_FAST, OP_FAST_WIDE, OP_QUAD_IO, OP_UNIQUE_ID, OP_INFO_ROW};
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    run(OP_NORMAL, $random(seed), 0, 1, 3, -1, 5'h00);
    run(OP_NORMAL, 32'hFFFFFFFF, 0, 1, 2, -1, 5'h10);
    run(OP_NORMAL, 32'hFF00FFFF, 0, 1, 2, 34, 5'h00);
    run(OP_NORMAL_WIDE, $random(seed), 0, 1, 1, 10, 5'h00);
    for (int i = 0; i < 3; i++) run(OP_NORMAL, $random(seed), 0, 1, 2, 36, 5'(1 << i));
    foreach (dl[i]) begin
      fast_dummy_i = dl[i];
      quad_dummy_i = dl[i];
      run(OP_FAST, $random(seed), 0, 1, 2, 35 + int'(dl[i]), 5'h00);
      run(OP_FAST_WIDE, $random(seed), 0, 1, 2, -1, 5'h00);
      run(OP_FAST, $random(seed), 1, 1, 2, 3, 5'h00);
    end
    foreach (qop[i]) run(qop[i], $random(seed), 1, 1, 3, -1, 5'h10);
    run(OP_NORMAL, $random(seed), 0, 0, 1, -1, 5'h08);
    run(OP_FAST, $random(seed), 0, 0, 1, -1, 5'h08);
    run(OP_FAST, $random(seed), 1, 0, 1, -1, 5'h08);
    run(8'h9F, $random(seed), 0, 0, 1, -1, 5'h00);
    run(OP_NORMAL, $random(seed), 1, 0, 1, -1, 5'h00);
    run(OP_NORMAL, $random(seed), 0, 1, 2, -1, 5'h00);
    final_report;
  end
endmodule
